/* File: src/apwm_top.v */
// Purpose: open-drain angle pulse output with error duty codes
// Assumes: fault and angle inputs come from logic on this clock
// Notes: the pin is released for the high level and pulled for low
//
// Behaviour
// - duty rises linearly with angle, 0 at 5 %, full turn at 95 %
// - first 5 % of each period high, last 5 % low
// - angle is sampled at period start and held for the period
// - 12-bit angle, top high time is 4095/4096 of 90 % plus 5 %
// - 4-bit step and 3-bit range pick one of 128 carriers
// - carrier follows the fixed grid, 3125 Hz down to 98 Hz
// - pin only pulls low, releases for high
// - report enable 0 ignores faults, 1 reacts per report style
// - style 0 releases the pin while an unmasked fault is present
// - style 1 halves the carrier and shows the top fault duty
// - only the highest-priority unmasked pending fault sets the duty
// - each fault has a mask bit; a masked fault still shows as pending but never changes the pin
// - thirteen ranked faults, duty from 5 % up by 5.625 %
// - watchdog, memory and self-test faults latch until power-up
// - averaging and corrected-memory faults show once then clear
// - pll and zero-crossing faults last while their cause lasts
// - undervoltage joins the two unmasked supply-low sources
// - field low and field high last while the field is out
// - saturation and temperature last while their cause lasts
// - host-cleared fault holds until a control write clears it
// - period runs free; angle taken at each rising edge
`timescale 1ns/1ns
`include "apwm_regs.vh"

module apwm_top (
	input wire clock,
	input wire resetn,
	input wire [3:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [31:0] bus_rdata_q,
	input wire [11:0] angle_in,
	input wire watchdog_fault,
	input wire nvm_uncorrectable_fault,
	input wire selftest_fault,
	input wire pll_unlock_fault,
	input wire zero_cross_fault,
	input wire averaging_fault,
	input wire analog_supply_low,
	input wire main_supply_low,
	input wire field_low_fault,
	input wire nvm_corrected_fault,
	input wire saturation_fault,
	input wire field_high_fault,
	input wire temp_range_fault,
	input wire host_cleared_fault,
	input wire pwm_pin_in,
	output reg pwm_pin_out_q,
	output reg pwm_pin_oe_q
);

localparam S_WAIT = 1'b0;
localparam S_RUN = 1'b1;

// configuration registers
reg [9:0] pulse_setup_row_q;
reg [14:0] pulse_error_mask_row_q;

// fault state
reg [12:0] pend_q;
reg [12:0] pend_d;
reg [12:0] snap_q;
reg [3:0] code_q;
reg halve_q;
reg release_q;

// period state
reg state_q;
reg [18:0] cnt_q;
reg [18:0] per_q;
reg [35:0] high_lim_q;

// pin level after two flops
reg pin_meta_q;
reg pin_sync_q;

// carrier
wire [17:0] carrier_period;
wire carrier_ready;

// decoded fields
wire [3:0] carrier_step_sel = pulse_setup_row_q[3:0];
wire [2:0] carrier_range_sel = pulse_setup_row_q[6:4];
wire err_report_en = pulse_setup_row_q[`APWM_SETUP_EN_BIT];
wire err_report_style = pulse_setup_row_q[`APWM_SETUP_STYLE_BIT];
wire [12:0] fault_mask = pulse_error_mask_row_q[12:0];

// bus decode
wire wr_setup = bus_wr && (bus_addr == `APWM_ADDR_SETUP);
wire wr_mask = bus_wr && (bus_addr == `APWM_ADDR_MASK);
wire wr_ctrl = bus_wr && (bus_addr == `APWM_ADDR_CTRL);
wire host_clear = wr_ctrl && bus_wdata[`APWM_CTRL_CLR_BIT];

// undervoltage combines the supply sources left unmasked
wire undervoltage_fault =
	(analog_supply_low &&
	!pulse_error_mask_row_q[`APWM_MASK_UVA_BIT]) ||
	(main_supply_low &&
	!pulse_error_mask_row_q[`APWM_MASK_MAIN_SUPPLY_LOW_BIT]);

// raw fault vector in priority order
wire [12:0] raw = {host_cleared_fault, temp_range_fault,
	field_high_fault, saturation_fault, nvm_corrected_fault,
	field_low_fault, undervoltage_fault, averaging_fault,
	zero_cross_fault, pll_unlock_fault, selftest_fault,
	nvm_uncorrectable_fault, watchdog_fault};

// effective faults after masking
wire [12:0] eff = pend_q & ~fault_mask;

// period boundary
wire last = (state_q == S_RUN) && (cnt_q == per_q - 19'h00001);
wire start = last || ((state_q == S_WAIT) && carrier_ready);

// scaled count: cnt times 81920
wire [35:0] cnt_scaled = {1'b0, cnt_q, 16'h0000} +
	{3'h0, cnt_q, 14'h0000};

// next period selection
reg [3:0] top_code;
reg err_now;
reg halve_n;
reg release_n;
reg [18:0] per_n;
reg [16:0] duty_n;
reg [12:0] clr_ev;
integer i;

apwm_carrier u_carrier (
	.clock(clock),
	.resetn(resetn),
	.step_sel(carrier_step_sel),
	.range_sel(carrier_range_sel),
	.period_q(carrier_period),
	.ready_q(carrier_ready)
);

// highest-priority unmasked fault
always @* begin
	top_code = 4'hF;
	for (i = `APWM_NFAULT - 1; i >= 0; i = i - 1) begin
		if (eff[i]) begin
			top_code = i[3:0];
		end
	end
end

// mode and duty of the period about to start
always @* begin
	err_now = err_report_en && (|eff);
	halve_n = err_now && err_report_style;
	release_n = err_now && !err_report_style;
	if (halve_n) begin
		per_n = {carrier_period, 1'b0};
		duty_n = `APWM_DUTY_EDGE +
			`APWM_DUTY_ERR_STEP * {13'h0000, top_code};
	end else begin
		per_n = {1'b0, carrier_period};
		duty_n = `APWM_DUTY_EDGE +
			`APWM_DUTY_ANGLE_LSB * {5'h00, angle_in};
	end
end

// one-shot faults leave once their period has been shown
always @* begin
	clr_ev = 13'h0000;
	clr_ev[`APWM_F_AVG] = last && snap_q[`APWM_F_AVG] &&
		(!halve_q || (code_q == `APWM_F_AVG) ||
		fault_mask[`APWM_F_AVG]);
	clr_ev[`APWM_F_NVMC] = last && snap_q[`APWM_F_NVMC] &&
		(!halve_q || (code_q == `APWM_F_NVMC) ||
		fault_mask[`APWM_F_NVMC]);
end

// pending faults; new events win over clears
always @* begin
	pend_d = raw;
	pend_d[`APWM_F_WDG] = pend_q[`APWM_F_WDG] |
		raw[`APWM_F_WDG];
	pend_d[`APWM_F_NVMU] = pend_q[`APWM_F_NVMU] |
		raw[`APWM_F_NVMU];
	pend_d[`APWM_F_SELF] = pend_q[`APWM_F_SELF] |
		raw[`APWM_F_SELF];
	pend_d[`APWM_F_AVG] = raw[`APWM_F_AVG] |
		(pend_q[`APWM_F_AVG] & ~clr_ev[`APWM_F_AVG]);
	pend_d[`APWM_F_NVMC] = raw[`APWM_F_NVMC] |
		(pend_q[`APWM_F_NVMC] & ~clr_ev[`APWM_F_NVMC]);
	pend_d[`APWM_F_HOST] = raw[`APWM_F_HOST] |
		(pend_q[`APWM_F_HOST] & ~host_clear);
end

always @(posedge clock) begin
	if (!resetn) begin
		pend_q <= 13'h0000;
	end else begin
		pend_q <= pend_d;
	end
end

// configuration writes
always @(posedge clock) begin
	if (!resetn) begin
		pulse_setup_row_q <= `APWM_SETUP_RESET;
		pulse_error_mask_row_q <= `APWM_MASK_RESET;
	end else begin
		if (wr_setup) begin
			pulse_setup_row_q <= bus_wdata[9:0];
		end
		if (wr_mask) begin
			pulse_error_mask_row_q <= bus_wdata[14:0];
		end
	end
end

// period sequencer, free running against angle updates
always @(posedge clock) begin
	if (!resetn) begin
		state_q <= S_WAIT;
		cnt_q <= 19'h00000;
		per_q <= 19'h00001;
		high_lim_q <= 36'h000000000;
		snap_q <= 13'h0000;
		code_q <= 4'hF;
		halve_q <= 1'b0;
		release_q <= 1'b1;
	end else begin
		case (state_q)
		S_WAIT: begin
			if (carrier_ready) begin
				state_q <= S_RUN;
			end
		end
		S_RUN: begin
			cnt_q <= cnt_q + 19'h00001;
		end
		default: begin
			state_q <= S_WAIT;
		end
		endcase
		if (start) begin
			cnt_q <= 19'h00000;
			per_q <= per_n;
			high_lim_q <= per_n * duty_n;
			snap_q <= pend_q;
			code_q <= top_code;
			halve_q <= halve_n;
			release_q <= release_n;
		end
	end
end

// open-drain driver: pull low past the high time, else release
always @(posedge clock) begin
	if (!resetn) begin
		pwm_pin_out_q <= 1'b0;
		pwm_pin_oe_q <= 1'b0;
	end else begin
		pwm_pin_out_q <= 1'b0;
		if (state_q != S_RUN || release_q) begin
			pwm_pin_oe_q <= 1'b0;
		end else begin
			pwm_pin_oe_q <= (cnt_scaled >= high_lim_q);
		end
	end
end

// pin level for status
always @(posedge clock) begin
	if (!resetn) begin
		pin_meta_q <= 1'b0;
		pin_sync_q <= 1'b0;
	end else begin
		pin_meta_q <= pwm_pin_in;
		pin_sync_q <= pin_meta_q;
	end
end

// register reads, data valid the cycle after the strobe
always @(posedge clock) begin
	if (!resetn) begin
		bus_rdata_q <= 32'h00000000;
	end else if (bus_rd) begin
		case (bus_addr)
		`APWM_ADDR_SETUP: begin
			bus_rdata_q <= {22'h000000, pulse_setup_row_q};
		end
		`APWM_ADDR_MASK: begin
			bus_rdata_q <= {17'h00000, pulse_error_mask_row_q};
		end
		`APWM_ADDR_STATUS: begin
			bus_rdata_q <= {4'h0, code_q, 5'h00, pin_sync_q,
				release_q, halve_q, 3'h0, pend_q};
		end
		default: begin
			bus_rdata_q <= 32'h00000000;
		end
		endcase
	end else begin
		bus_rdata_q <= 32'h00000000;
	end
end

endmodule // apwm_top

/* File: src/apwm_regs.vh */
// Purpose: constants for the angle pulse output block
// Assumes: 20 MHz core clock, 4-bit byte address on the register port
// Notes: duty figures are in units of 1/81920 of a carrier period
`ifndef APWM_REGS_VH
`define APWM_REGS_VH

// core clock rate in Hz (20 000 000)
`define APWM_CLK_HZ 25'h1312D00

// register byte offsets
`define APWM_ADDR_SETUP 4'h0
`define APWM_ADDR_MASK 4'h4
`define APWM_ADDR_CTRL 4'h8
`define APWM_ADDR_STATUS 4'hC

// setup word: step, range, report enable, report style
`define APWM_SETUP_STEP_LSB 0
`define APWM_SETUP_RANGE_LSB 4
`define APWM_SETUP_EN_BIT 8
`define APWM_SETUP_STYLE_BIT 9
`define APWM_SETUP_RESET 10'h000

// mask word: one bit per fault, plus two supply masks
`define APWM_MASK_UVA_BIT 13
`define APWM_MASK_MAIN_SUPPLY_LOW_BIT 14
`define APWM_MASK_RESET 15'h0000

// control word: write one clears the host-cleared fault
`define APWM_CTRL_CLR_BIT 0

// status word fields
`define APWM_STAT_ERR_BIT 16
`define APWM_STAT_REL_BIT 17
`define APWM_STAT_PIN_BIT 18
`define APWM_STAT_CODE_LSB 24

// fault index equals priority minus one
`define APWM_F_WDG 0
`define APWM_F_NVMU 1
`define APWM_F_SELF 2
`define APWM_F_PLL 3
`define APWM_F_ZERO 4
`define APWM_F_AVG 5
`define APWM_F_UV 6
`define APWM_F_FLOW 7
`define APWM_F_NVMC 8
`define APWM_F_SAT 9
`define APWM_F_FHIGH 10
`define APWM_F_TEMP 11
`define APWM_F_HOST 12
`define APWM_NFAULT 13

// duty units: full period 81920, 5 % edge 4096
`define APWM_DUTY_FULL 17'h14000
`define APWM_DUTY_EDGE 17'h01000
// 90 % span over 4096 angle codes
`define APWM_DUTY_ANGLE_LSB 17'h00012
// 5.625 % between error codes
`define APWM_DUTY_ERR_STEP 17'h01200

`endif

/* File: src/apwm_carrier.v */
// Purpose: carrier period in clock cycles from step and range selects
// Assumes: selects are quasi-static configuration
// Notes: repeats a restoring division, 26 cycles per result
`timescale 1ns/1ns
`include "apwm_regs.vh"

module apwm_carrier (
	input wire clock,
	input wire resetn,
	input wire [3:0] step_sel,
	input wire [2:0] range_sel,
	output reg [17:0] period_q,
	output reg ready_q
);

// carrier in Hz, step 15 in the top slot, step 0 in the low slot
localparam [191:0] BAND0 = {12'd2797, 12'd2817, 12'd2837, 12'd2857,
	12'd2878, 12'd2899, 12'd2920, 12'd2941, 12'd2963, 12'd2985,
	12'd3008, 12'd3030, 12'd3053, 12'd3077, 12'd3101, 12'd3125};
localparam [191:0] BAND1 = {12'd2299, 12'd2326, 12'd2353, 12'd2381,
	12'd2410, 12'd2439, 12'd2469, 12'd2500, 12'd2532, 12'd2564,
	12'd2597, 12'd2632, 12'd2667, 12'd2703, 12'd2740, 12'd2778};
localparam [191:0] BAND2 = {12'd1695, 12'd1724, 12'd1754, 12'd1786,
	12'd1818, 12'd1852, 12'd1887, 12'd1923, 12'd1961, 12'd2000,
	12'd2041, 12'd2083, 12'd2128, 12'd2174, 12'd2222, 12'd2273};
localparam [191:0] BAND3 = {12'd1111, 12'd1136, 12'd1163, 12'd1190,
	12'd1220, 12'd1250, 12'd1282, 12'd1316, 12'd1351, 12'd1389,
	12'd1429, 12'd1471, 12'd1515, 12'd1563, 12'd1613, 12'd1667};
localparam [191:0] BAND4 = {12'd658, 12'd676, 12'd694, 12'd714,
	12'd735, 12'd758, 12'd781, 12'd806, 12'd833, 12'd862,
	12'd893, 12'd926, 12'd962, 12'd1000, 12'd1042, 12'd1087};
localparam [191:0] BAND5 = {12'd362, 12'd373, 12'd385, 12'd397,
	12'd410, 12'd424, 12'd439, 12'd455, 12'd472, 12'd490,
	12'd510, 12'd532, 12'd556, 12'd581, 12'd610, 12'd641};
localparam [191:0] BAND6 = {12'd191, 12'd197, 12'd203, 12'd210,
	12'd217, 12'd225, 12'd234, 12'd243, 12'd253, 12'd263,
	12'd275, 12'd287, 12'd301, 12'd316, 12'd333, 12'd352};
localparam [191:0] BAND7 = {12'd98, 12'd101, 12'd105, 12'd108,
	12'd112, 12'd116, 12'd121, 12'd126, 12'd131, 12'd137,
	12'd143, 12'd150, 12'd157, 12'd166, 12'd175, 12'd185};

reg [191:0] band;
reg [11:0] freq;
reg [4:0] cnt_q;
reg [24:0] num_q;
reg [11:0] rem_q;
reg [11:0] div_q;
reg [16:0] quo_q;
wire [12:0] trial = {rem_q, num_q[24]};
wire fits = (trial >= {1'b0, div_q});
wire [12:0] diff = trial - {1'b0, div_q};

always @* begin
	case (range_sel)
	3'h0: band = BAND0;
	3'h1: band = BAND1;
	3'h2: band = BAND2;
	3'h3: band = BAND3;
	3'h4: band = BAND4;
	3'h5: band = BAND5;
	3'h6: band = BAND6;
	default: band = BAND7;
	endcase
	freq = band[step_sel * 12 +: 12];
end

always @(posedge clock) begin
	if (!resetn) begin
		cnt_q <= 5'h00;
		num_q <= 25'h0000000;
		rem_q <= 12'h000;
		div_q <= 12'h001;
		quo_q <= 17'h00000;
		period_q <= 18'h00000;
		ready_q <= 1'b0;
	end else if (cnt_q == 5'h00) begin
		num_q <= `APWM_CLK_HZ;
		rem_q <= 12'h000;
		div_q <= freq;
		cnt_q <= 5'h19;
	end else begin
		num_q <= {num_q[23:0], 1'b0};
		rem_q <= fits ? diff[11:0] : trial[11:0];
		quo_q <= {quo_q[15:0], fits};
		cnt_q <= cnt_q - 5'h01;
		if (cnt_q == 5'h01) begin
			period_q <= {quo_q, fits};
			ready_q <= 1'b1;
		end
	end
end

endmodule // apwm_carrier

/* File: tb/apwm_monitor.sv */
// Purpose: port checker for the angle pulse output block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to apwm_top after the module
`timescale 1ns/1ns
module apwm_monitor (
	input wire clock,
	input wire resetn,
	input wire [3:0] bus_addr,
	input wire [31:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	input wire [31:0] bus_rdata_q,
	input wire watchdog_fault,
	input wire pll_unlock_fault,
	input wire host_cleared_fault,
	input wire pwm_pin_out_q,
	input wire pwm_pin_oe_q
);
	wire clr_wr = bus_wr && bus_addr == 4'h8 && bus_wdata[0];
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence rd_stat;
		bus_rd && bus_addr == 4'hC;
	endsequence
	sequence host_held;
		host_cleared_fault ##1 !clr_wr [*2];
	endsequence
	chk_pin_out: assert property (!pwm_pin_out_q)
		else $error("pin output driven high");
	chk_rd_idle: assert property (!bus_rd |=> bus_rdata_q == 32'h0)
		else $error("read data outside read slot");
	chk_ctrl_zero: assert property (bus_rd && bus_addr == 4'h8
		|=> bus_rdata_q == 32'h0)
		else $error("control word reads nonzero");
	chk_unmapped_zero: assert property (bus_rd && bus_addr[1:0] != 2'h0
		|=> bus_rdata_q == 32'h0)
		else $error("unmapped read nonzero");
	chk_setup_back: assert property ((bus_wr && bus_addr == 4'h0) ##1
		(bus_rd && bus_addr == 4'h0)
		|=> bus_rdata_q == ($past(bus_wdata, 2) & 32'h3FF))
		else $error("setup readback wrong");
	chk_high_head: assert property ($fell(pwm_pin_oe_q)
		|-> !pwm_pin_oe_q [*8])
		else $error("leading high region too short");
	chk_low_tail: assert property ($rose(pwm_pin_oe_q)
		|-> pwm_pin_oe_q [*8])
		else $error("trailing low region too short");
	chk_pll_seen: assert property (pll_unlock_fault [*3] ##0 rd_stat
		|=> bus_rdata_q[3])
		else $error("pll fault not pending");
	chk_host_held: assert property (host_held ##0 rd_stat
		|=> bus_rdata_q[12])
		else $error("host fault not latched");
	chk_host_clr: assert property ((!host_cleared_fault [*3] ##0 clr_wr)
		##1 (!host_cleared_fault && bus_rd && bus_addr == 4'hC)
		|=> !bus_rdata_q[12])
		else $error("host fault not cleared");
	chk_wdg_keep: assert property (watchdog_fault ##[3:1000] rd_stat
		|=> bus_rdata_q[0])
		else $error("watchdog fault not kept");
endmodule // apwm_monitor
bind apwm_top apwm_monitor u_mon (
	.clock(clock),
	.resetn(resetn),
	.bus_addr(bus_addr),
	.bus_wdata(bus_wdata),
	.bus_wr(bus_wr),
	.bus_rd(bus_rd),
	.bus_rdata_q(bus_rdata_q),
	.watchdog_fault(watchdog_fault),
	.pll_unlock_fault(pll_unlock_fault),
	.host_cleared_fault(host_cleared_fault),
	.pwm_pin_out_q(pwm_pin_out_q),
	.pwm_pin_oe_q(pwm_pin_oe_q)
);

/* File: tb/apwm_host.sv */
// Purpose: host model measuring period and high time on the pin
// Assumes: pin already resolved with its pull-up
// Notes: one report per rising edge; first report after a change is stale
`timescale 1ns/1ns
module apwm_host (
	input wire clock,
	input wire resetn,
	input wire pin,
	output reg [18:0] high_q,
	output reg [18:0] per_q,
	output reg done_q
);
	reg [18:0] cnt_q;
	reg [18:0] hcnt_q;
	reg pin_q;
	always @(posedge clock) begin
		pin_q <= pin;
		done_q <= 1'b0;
		if (!resetn) begin
			pin_q <= 1'b1;
			cnt_q <= 19'h0;
			hcnt_q <= 19'h0;
		end else if (pin && !pin_q) begin
			// period and high time both taken
			per_q <= cnt_q;
			high_q <= hcnt_q;
			done_q <= 1'b1;
			cnt_q <= 19'h1;
			hcnt_q <= 19'h1;
		end else begin
			cnt_q <= cnt_q + 19'h1;
			hcnt_q <= hcnt_q + {18'h0, pin};
		end
	end
endmodule // apwm_host

/* File: tb/tb_angle_pwm_output_with_error_codes.sv */
// Purpose: self-checking bench for the angle pulse output block
// Assumes: 20 MHz clock, fastest carrier of 6400 cycles
// Notes: error mode doubles the period to 12800 cycles
`timescale 1ns/1ns
module tb_angle_pwm_output_with_error_codes;
	reg clock = 1'b0;
	reg resetn = 1'b0;
	reg [3:0] bus_addr = 4'h0;
	reg [31:0] bus_wdata = 32'h0;
	reg bus_wr = 1'b0;
	reg bus_rd = 1'b0;
	reg [11:0] ang = 12'h000;
	reg [14:0] f = 15'h0000;
	wire [31:0] bus_rdata_q;
	wire pwm_pin_out_q;
	wire pwm_pin_oe_q;
	wire [18:0] m_high;
	wire [18:0] m_per;
	wire m_done;
	wire pin_w = pwm_pin_oe_q ? pwm_pin_out_q : 1'b1;
	integer n_errors = 0;
	integer compares = 0;
	logic [31:0] st;
	always #25 clock = ~clock;
	apwm_top DUT (
		.clock(clock), .resetn(resetn), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata_q(bus_rdata_q), .angle_in(ang),
		.watchdog_fault(f[0]), .nvm_uncorrectable_fault(f[1]),
		.selftest_fault(f[2]), .pll_unlock_fault(f[3]),
		.zero_cross_fault(f[4]), .averaging_fault(f[5]),
		.analog_supply_low(f[13]), .main_supply_low(f[14]),
		.field_low_fault(f[7]), .nvm_corrected_fault(f[8]),
		.saturation_fault(f[9]), .field_high_fault(f[10]),
		.temp_range_fault(f[11]), .host_cleared_fault(f[12]),
		.pwm_pin_in(pin_w), .pwm_pin_out_q(pwm_pin_out_q),
		.pwm_pin_oe_q(pwm_pin_oe_q)
	);
	apwm_host u_host (
		.clock(clock), .resetn(resetn), .pin(pin_w),
		.high_q(m_high), .per_q(m_per), .done_q(m_done)
	);
	task results;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares = compares + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clock);
	endtask
	task rd(input logic [3:0] a, output logic [31:0] v);
		bus_wr <= 1'b0;
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clock);
		bus_rd <= 1'b0;
		@(negedge clock);
		v = bus_rdata_q;
		@(posedge clock);
	endtask
	task meas(input logic [18:0] eh, input logic [18:0] ep);
		integer i;
		integer k;
		for (k = 0; k < 2; k++) begin
			@(negedge clock);
			for (i = 0; i < 30000 && m_done !== 1'b1; i++)
				@(negedge clock);
		end
		chk("high time", {13'h0, eh}, {13'h0, m_high});
		chk("period", {13'h0, ep}, {13'h0, m_per});
		@(posedge clock);
	endtask
	task t_angle_min;
		meas(19'd320, 19'd6400);
	endtask
	task t_regs;
		rd(4'h0, st);
		chk("setup reset", 32'h0, st);
		rd(4'h4, st);
		chk("mask reset", 32'h0, st);
		wr(4'h0, 32'hFFFFFFFF);
		rd(4'h0, st);
		chk("setup", 32'h000003FF, st);
		wr(4'h0, 32'h0);
		wr(4'h4, 32'hFFFFFFFF);
		rd(4'h4, st);
		chk("mask", 32'h00007FFF, st);
		wr(4'h4, 32'h0);
		rd(4'h2, st);
		chk("unmapped", 32'h0, st);
		rd(4'h8, st);
		chk("control", 32'h0, st);
	endtask
	task t_angle_max;
		ang <= 12'hFFF;
		f <= 15'h0008;
		meas(19'd6079, 19'd6400);
	endtask
	task t_err;
		f <= 15'h0818;
		wr(4'h4, 32'h00000008);
		wr(4'h0, 32'h00000300);
		bus_wr <= 1'b0;
		meas(19'd3520, 19'd12800);
		rd(4'hC, st);
		chk("code", 32'h04010000, st & 32'h0F010000);
	endtask
	task t_release;
		integer i;
		integer n;
		n = 0;
		f <= 15'h6FB8;
		wr(4'h0, 32'h00000100);
		bus_wr <= 1'b0;
		repeat (13000) @(posedge clock);
		for (i = 0; i < 6500; i++) begin
			@(negedge clock);
			if (pwm_pin_oe_q !== 1'b0)
				n = n + 1;
		end
		chk("pin pulls", 32'h0, n);
		@(posedge clock);
		rd(4'hC, st);
		chk("released", 32'h00060FF8, st & 32'h00071FFF);
	endtask
	task t_carrier;
		ang <= 12'h000;
		wr(4'h0, 32'h0000000F);
		bus_wr <= 1'b0;
		// let the divider settle on the new step first
		repeat (60) @(posedge clock);
		meas(19'd358, 19'd7150);
		rd(4'hC, st);
		chk("faults", 32'h00000007, st & 32'h00031FFF);
	endtask
	task t_host;
		f <= 15'h1000;
		@(posedge clock);
		f <= 15'h0000;
		@(posedge clock);
		rd(4'hC, st);
		chk("host set", 32'h00001000, st & 32'h00001000);
		wr(4'h8, 32'h00000001);
		rd(4'hC, st);
		chk("host clear", 32'h0, st & 32'h00001000);
	endtask
	task t_perm;
		f <= 15'h0007;
		@(posedge clock);
		f <= 15'h0000;
		repeat (4) @(posedge clock);
		rd(4'hC, st);
		chk("permanent", 32'h00000007, st & 32'h00000007);
	endtask
	initial begin
		#5000000;
		n_errors = n_errors + 1;
		results;
	end
	initial begin
		repeat (12) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		t_angle_min;
		t_regs;
		t_angle_max;
		t_err;
		t_release;
		t_host;
		t_perm;
		t_carrier;
		results;
	end
endmodule // tb_angle_pwm_output_with_error_codes
